// ==== shared/sae_consts.vh ====
/*
 Shared constants for the store/add execution block.
 Assumes inclusion by bare name from each design file.
*/
`ifndef SAE_CONSTS_VH
`define SAE_CONSTS_VH
// ==========================================
// Operation codes on op_code
`define SAE_OP_W 4
`define SAE_OP_FULLWORD_SAVE 4'h1
`define SAE_OP_HALFWORD_SAVE 4'h2
`define SAE_OP_BYTE_SAVE 4'h3
`define SAE_OP_BYTE_SAVE_AUTOINC 4'h4
`define SAE_OP_ADD_IMMEDIATE 4'h5
`define SAE_OP_ADD_FULLREG 4'h6
`define SAE_OP_ADD_HALFREG 4'h7
`define SAE_OP_ADD_BYTE_REG 4'h8
// ==========================================
// Register layout: byte X [21:16] (6 bits), byte 0 [15:8], byte 1 [7:0]
`define SAE_REG_W 22
`define SAE_BYTEX_HI 21
`define SAE_BYTEX_LO 16
`define SAE_BYTE0_HI 15
`define SAE_BYTE0_LO 8
`define SAE_BYTE1_HI 7
`define SAE_BYTE1_LO 0
`define SAE_REG_RST 22'h00_0000
// ==========================================
// Substitute base-pointer external register numbers
`define SAE_XREG_BYTE_BASE 8'h44
`define SAE_XREG_HALF_BASE 8'h45
`define SAE_XREG_FULL_BASE 8'h46
`define SAE_DISP_FULL_MAX 7'h7c
`define SAE_DISP_HALF_MAX 7'h7e
`define SAE_DISP_BYTE_MAX 7'h7f
`endif

// ==== src/sae_regfile.v ====
/*
 Eight general registers of 22 bits with one write port and two read ports.
 Assumes one write per cycle from the execute sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sae_consts.vh"
module sae_regfile (
  input wire ref_clk,
  input wire sys_rst,
  input wire wr_en,
  input wire [2:0] wr_addr,
  input wire [`SAE_REG_W-1:0] wr_data,
  input wire [2:0] rd_a_addr,
  output wire [`SAE_REG_W-1:0] rd_a_data,
  input wire [2:0] rd_b_addr,
  output wire [`SAE_REG_W-1:0] rd_b_data
);
  reg [`SAE_REG_W-1:0] gpr_reg [0:7];
  genvar gi;
  // ==========================================
  // Storage
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_gpr
      always @(posedge ref_clk)
      begin
        if (sys_rst)
          gpr_reg[gi] <= `SAE_REG_RST;
        else if (wr_en && wr_addr == gi)
          gpr_reg[gi] <= wr_data;
      end
    end
  endgenerate
  assign rd_a_data = gpr_reg[rd_a_addr];
  assign rd_b_data = gpr_reg[rd_b_addr];
endmodule
`default_nettype wire

// ==== src/sae_addr_gen.v ====
/*
 Effective storage address: base plus displacement, with substitute bases.
 Assumes substitute pointers are supplied already initialised by software.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sae_consts.vh"
module sae_addr_gen (
  input wire [`SAE_OP_W-1:0] op,
  input wire [2:0] base_sel,
  input wire [`SAE_REG_W-1:0] base_val,
  input wire [6:0] disp,
  input wire [`SAE_REG_W-1:0] xreg_full_base,
  input wire [`SAE_REG_W-1:0] xreg_half_base,
  input wire [`SAE_REG_W-1:0] xreg_byte_base,
  output reg [`SAE_REG_W-1:0] eff_addr
);
  reg [`SAE_REG_W-1:0] base;
  reg [6:0] dsp;
  reg [`SAE_REG_W-1:0] sum;
  always @*
  begin
    base = base_val;
    dsp = disp;
    if (base_sel == 3'h0)
    begin
      case (op)
        `SAE_OP_FULLWORD_SAVE: base = xreg_full_base;
        `SAE_OP_HALFWORD_SAVE: base = xreg_half_base;
        `SAE_OP_BYTE_SAVE: base = xreg_byte_base;
        default: base = base_val;
      endcase
    end
    case (op)
      `SAE_OP_FULLWORD_SAVE: dsp = disp & `SAE_DISP_FULL_MAX;
      `SAE_OP_HALFWORD_SAVE: dsp = disp & `SAE_DISP_HALF_MAX;
      `SAE_OP_BYTE_SAVE: dsp = disp & `SAE_DISP_BYTE_MAX;
      `SAE_OP_BYTE_SAVE_AUTOINC: dsp = 7'h00;
      default: dsp = disp;
    endcase
    sum = base + {15'h0000, dsp};
    eff_addr = sum;
    // Halfword-aligned storage: low bit dropped for word and halfword
    if (op == `SAE_OP_FULLWORD_SAVE || op == `SAE_OP_HALFWORD_SAVE)
      eff_addr = {sum[`SAE_REG_W-1:1], 1'b0};
  end
endmodule
`default_nettype wire

// ==== src/sae_execute.v ====
/*
 Execution of the store group and first add group of the central control unit.
 Assumes one instruction per op_valid pulse, already decoded into fields, and
 storage that accepts a write strobe at any cycle.
*/
// Behaviour
// - Word and halfword stores drop address bit zero
// - Word store base zero uses pointer 0x46
// - Source register zero stores all zeros
// - Halfword store writes bytes 0,1, even displacement
// - Halfword store base zero uses pointer 0x45
// - Byte store picks byte by select bit
// - Byte store base zero uses pointer 0x44
// - Byte formats force register low bit one
// - Autoincrement byte store bumps base by one
// - Autoincrement with base zero raises check
// - Same register: increment before byte extraction
// - Stores never alter condition latches
// - Immediate add sets carry and zero per field
// - Byte X excluded from condition decisions except in full register add and the select-1 byte register add carry
// - Full register add, unsigned, sets latches
// - Halfword add keeps byte X, carry from byte 0
// - Add to register zero branches, latches kept
// - Byte register add zero-extends selected byte
// - Register zero is the instruction address
// - Registers are 22 bits, word store 22 bits
`timescale 1ns/1ps
`default_nettype none
`include "sae_consts.vh"
module sae_execute (
  input wire ref_clk,
  input wire sys_rst,
  input wire op_valid,
  input wire [`SAE_OP_W-1:0] op_code,
  input wire [2:0] op_r1,
  input wire [2:0] op_r2,
  input wire [1:0] op_rbyte,
  input wire dest_byte_sel,
  input wire src_byte_sel,
  input wire [6:0] op_disp,
  input wire [7:0] op_imm,
  input wire [`SAE_REG_W-1:0] xreg_full_base,
  input wire [`SAE_REG_W-1:0] xreg_half_base,
  input wire [`SAE_REG_W-1:0] xreg_byte_base,
  output reg mem_wr,
  output reg [`SAE_REG_W-1:0] mem_addr,
  output reg [`SAE_REG_W-1:0] mem_wdata,
  output reg [1:0] mem_size,
  output reg carry_latch,
  output reg zero_latch,
  output reg branch_taken,
  output reg [`SAE_REG_W-1:0] branch_addr,
  output reg invalid_op_check,
  output reg done
);
  // ==========================================
  // States
  localparam SEQ_IDLE = 3'b001;
  localparam SEQ_EXEC = 3'b010;
  localparam SEQ_WRITE = 3'b100;
  localparam SZ_BYTE = 2'h0;
  localparam SZ_HALF = 2'h1;
  localparam SZ_WORD = 2'h2;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`SAE_OP_W-1:0] op_reg;
  reg [2:0] ra_reg;
  reg [2:0] rb_reg;
  reg dsel_reg;
  reg ssel_reg;
  reg [6:0] disp_reg;
  reg [7:0] imm_reg;

  wire [`SAE_REG_W-1:0] ra_val;
  wire [`SAE_REG_W-1:0] rb_val;
  wire [`SAE_REG_W-1:0] eff_addr;
  reg rf_wr;
  reg [2:0] rf_waddr;
  reg [`SAE_REG_W-1:0] rf_wdata;

  // ==========================================
  // Decode latch: byte formats take a two-bit field with low bit forced
  wire byte_fmt = (op_code == `SAE_OP_BYTE_SAVE) ||
                  (op_code == `SAE_OP_BYTE_SAVE_AUTOINC) ||
                  (op_code == `SAE_OP_ADD_IMMEDIATE) ||
                  (op_code == `SAE_OP_ADD_BYTE_REG);
  wire [2:0] r1_eff = byte_fmt ? {op_rbyte, 1'b1} : op_r1;
  wire [2:0] r2_eff = (op_code == `SAE_OP_ADD_BYTE_REG) ?
                      {op_r2[2:1], 1'b1} : op_r2;

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      op_reg <= 4'h0;
      ra_reg <= 3'h0;
      rb_reg <= 3'h0;
      dsel_reg <= 1'b0;
      ssel_reg <= 1'b0;
      disp_reg <= 7'h00;
      imm_reg <= 8'h00;
    end
    else if (state_reg == SEQ_IDLE && op_valid)
    begin
      op_reg <= op_code;
      ra_reg <= r1_eff;
      rb_reg <= r2_eff;
      dsel_reg <= dest_byte_sel;
      ssel_reg <= src_byte_sel;
      disp_reg <= op_disp;
      imm_reg <= op_imm;
    end
  end

  // ==========================================
  // Register file and address path
  sae_regfile u_regfile (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_en(rf_wr),
    .wr_addr(rf_waddr),
    .wr_data(rf_wdata),
    .rd_a_addr(ra_reg),
    .rd_a_data(ra_val),
    .rd_b_addr(rb_reg),
    .rd_b_data(rb_val)
  );

  sae_addr_gen u_addr_gen (
    .op(op_reg),
    .base_sel(rb_reg),
    .base_val(rb_val),
    .disp(disp_reg),
    .xreg_full_base(xreg_full_base),
    .xreg_half_base(xreg_half_base),
    .xreg_byte_base(xreg_byte_base),
    .eff_addr(eff_addr)
  );

  // ==========================================
  // Arithmetic
  // Register zero reads as zero data for stores, never as itself
  wire [`SAE_REG_W-1:0] src_val = (ra_reg == 3'h0) ? `SAE_REG_RST : ra_val;
  wire [`SAE_REG_W-1:0] inc_base = rb_val + 22'h00_0001;
  // Shared register: byte taken from the already incremented value
  wire [`SAE_REG_W-1:0] byte_src = (ra_reg == rb_reg) ? inc_base : ra_val;
  wire [7:0] byte_pick = ssel_reg ? byte_src[`SAE_BYTE1_HI:`SAE_BYTE1_LO] :
                         byte_src[`SAE_BYTE0_HI:`SAE_BYTE0_LO];
  wire [7:0] plain_pick = dsel_reg ? ra_val[`SAE_BYTE1_HI:`SAE_BYTE1_LO] :
                          ra_val[`SAE_BYTE0_HI:`SAE_BYTE0_LO];

  wire [`SAE_REG_W:0] full_sum = {1'b0, ra_val} + {1'b0, rb_val};
  wire [16:0] half_sum = {1'b0, ra_val[15:0]} + {1'b0, rb_val[15:0]};
  wire [8:0] imm_b0 = {1'b0, ra_val[15:8]} + {1'b0, imm_reg};
  wire [16:0] imm_hw = {1'b0, ra_val[15:0]} + {9'h000, imm_reg};
  wire [7:0] bytereg_op = ssel_reg ? rb_val[7:0] : rb_val[15:8];
  wire [13:0] bytereg_x0 = ra_val[21:8] + {6'h00, bytereg_op};
  wire [`SAE_REG_W:0] bytereg_all = {1'b0, ra_val} + {15'h0000, bytereg_op};

  // ==========================================
  // Sequencer
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      SEQ_IDLE: if (op_valid) state_next = SEQ_EXEC;
      SEQ_EXEC: state_next = SEQ_WRITE;
      SEQ_WRITE: state_next = SEQ_IDLE;
      default: state_next = SEQ_IDLE;
    endcase
  end

  // Register write-back, issued in the execute cycle
  always @*
  begin
    rf_wr = 1'b0;
    rf_waddr = ra_reg;
    rf_wdata = ra_val;
    if (state_reg == SEQ_EXEC)
    begin
      case (op_reg)
        `SAE_OP_BYTE_SAVE_AUTOINC:
        begin
          rf_wr = (rb_reg != 3'h0);
          rf_waddr = rb_reg;
          rf_wdata = inc_base;
        end
        `SAE_OP_ADD_IMMEDIATE:
        begin
          rf_wr = 1'b1;
          // Byte X rides along unaffected; byte 1 kept when select is 0
          if (dsel_reg)
            rf_wdata = {ra_val[21:16], imm_hw[15:0]};
          else
            rf_wdata = {ra_val[21:16], imm_b0[7:0], ra_val[7:0]};
        end
        `SAE_OP_ADD_FULLREG:
        begin
          rf_wr = 1'b1;
          rf_wdata = full_sum[`SAE_REG_W-1:0];
        end
        `SAE_OP_ADD_HALFREG:
        begin
          rf_wr = 1'b1;
          rf_wdata = {ra_val[21:16], half_sum[15:0]};
        end
        `SAE_OP_ADD_BYTE_REG:
        begin
          rf_wr = 1'b1;
          if (dsel_reg)
            rf_wdata = bytereg_all[`SAE_REG_W-1:0];
          else
            rf_wdata = {bytereg_x0, ra_val[7:0]};
        end
        default: rf_wr = 1'b0;
      endcase
    end
  end

  // ==========================================
  // Outputs and condition latches
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= SEQ_IDLE;
      mem_wr <= 1'b0;
      mem_addr <= `SAE_REG_RST;
      mem_wdata <= `SAE_REG_RST;
      mem_size <= SZ_BYTE;
      carry_latch <= 1'b0;
      zero_latch <= 1'b0;
      branch_taken <= 1'b0;
      branch_addr <= `SAE_REG_RST;
      invalid_op_check <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mem_wr <= 1'b0;
      branch_taken <= 1'b0;
      invalid_op_check <= 1'b0;
      done <= (state_reg == SEQ_EXEC);
      if (state_reg == SEQ_EXEC)
      begin
        // Latches change only in the add cases below
        case (op_reg)
          `SAE_OP_FULLWORD_SAVE:
          begin
            mem_wr <= 1'b1;
            mem_addr <= eff_addr;
            mem_size <= SZ_WORD;
            mem_wdata <= src_val;
          end
          `SAE_OP_HALFWORD_SAVE:
          begin
            mem_wr <= 1'b1;
            mem_addr <= eff_addr;
            mem_size <= SZ_HALF;
            mem_wdata <= {6'h00, src_val[15:0]};
          end
          `SAE_OP_BYTE_SAVE:
          begin
            mem_wr <= 1'b1;
            mem_addr <= eff_addr;
            mem_size <= SZ_BYTE;
            mem_wdata <= {14'h0000, plain_pick};
          end
          `SAE_OP_BYTE_SAVE_AUTOINC:
          begin
            if (rb_reg == 3'h0)
              invalid_op_check <= 1'b1;
            else
            begin
              mem_wr <= 1'b1;
              mem_addr <= rb_val;
              mem_size <= SZ_BYTE;
              mem_wdata <= {14'h0000, byte_pick};
            end
          end
          `SAE_OP_ADD_IMMEDIATE:
          begin
            // Byte X ignored for both latches
            if (dsel_reg)
            begin
              carry_latch <= imm_hw[16];
              zero_latch <= (imm_hw[15:0] == 16'h0000);
            end
            else
            begin
              carry_latch <= imm_b0[8];
              zero_latch <= (imm_b0[7:0] == 8'h00);
            end
          end
          `SAE_OP_ADD_FULLREG:
          begin
            if (ra_reg == 3'h0)
            begin
              branch_taken <= 1'b1;
              branch_addr <= full_sum[`SAE_REG_W-1:0];
            end
            else
            begin
              carry_latch <= full_sum[`SAE_REG_W];
              zero_latch <= (full_sum[`SAE_REG_W-1:0] == 22'h00_0000);
            end
          end
          `SAE_OP_ADD_HALFREG:
          begin
            if (ra_reg == 3'h0)
            begin
              branch_taken <= 1'b1;
              branch_addr <= {ra_val[21:16], half_sum[15:0]};
            end
            else
            begin
              carry_latch <= half_sum[16];
              zero_latch <= (half_sum[15:0] == 16'h0000);
            end
          end
          `SAE_OP_ADD_BYTE_REG:
          begin
            // Carry is overflow out of byte 0 when select is 0, sum bit 16 (low bit of byte X) when 1; zero ignores byte X
            carry_latch <= dsel_reg ? bytereg_all[16] :
                           (({1'b0, ra_val[15:8]} + {1'b0, bytereg_op}) > 9'h0ff);
            zero_latch <= dsel_reg ? (bytereg_all[15:0] == 16'h0000) :
                          (bytereg_x0[7:0] == 8'h00);
          end
          default: done <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/sae_execute_chk.sv ====
/*
 Port checker for sae_execute, bound to every instance of it.
 Assumes one operation per three cycles and fields held while busy.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sae_consts.vh"
module sae_execute_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [`SAE_OP_W-1:0] op_code,
  input wire logic [2:0] op_r1,
  input wire logic [2:0] op_r2,
  input wire logic [6:0] op_disp,
  input wire logic [`SAE_REG_W-1:0] xreg_full_base,
  input wire logic [`SAE_REG_W-1:0] xreg_half_base,
  input wire logic [`SAE_REG_W-1:0] xreg_byte_base,
  input wire logic mem_wr,
  input wire logic [`SAE_REG_W-1:0] mem_addr,
  input wire logic [`SAE_REG_W-1:0] mem_wdata,
  input wire logic [1:0] mem_size,
  input wire logic carry_latch,
  input wire logic zero_latch,
  input wire logic branch_taken,
  input wire logic invalid_op_check
);
  // ==========================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire_even_a: assert property (mem_wr && mem_size != 2'h0 |-> !mem_addr[0])
    else $error("word or half store at odd address");
  store_latch_a: assert property (mem_wr |-> $stable(carry_latch) && $stable(zero_latch))
    else $error("store changed condition latches");
  branch_latch_a: assert property (branch_taken |-> $stable({carry_latch, zero_latch}))
    else $error("branch changed condition latches");
  check_nowr_a: assert property (invalid_op_check |-> !mem_wr)
    else $error("refused store still wrote");
  zero_src_a: assert property (mem_wr && $past(op_code, 2) == `SAE_OP_FULLWORD_SAVE
    && $past(op_r1, 2) == 3'h0 |-> mem_wdata == 22'h00_0000)
    else $error("register zero source not stored as zeros");
  full_base_a: assert property (mem_wr && $past(op_code, 2) == `SAE_OP_FULLWORD_SAVE
    && $past(op_r2, 2) == 3'h0 |-> mem_addr == (($past(xreg_full_base, 2)
    + {15'h0, $past(op_disp, 2) & 7'h7c}) & 22'h3f_fffe))
    else $error("word substitute base wrong");
  half_base_a: assert property (mem_wr && $past(op_code, 2) == `SAE_OP_HALFWORD_SAVE
    && $past(op_r2, 2) == 3'h0 |-> mem_addr == (($past(xreg_half_base, 2)
    + {15'h0, $past(op_disp, 2) & 7'h7e}) & 22'h3f_fffe))
    else $error("half substitute base wrong");
  byte_base_a: assert property (mem_wr && $past(op_code, 2) == `SAE_OP_BYTE_SAVE
    && $past(op_r2, 2) == 3'h0 |-> mem_addr == $past(xreg_byte_base, 2)
    + {15'h0, $past(op_disp, 2)})
    else $error("byte substitute base wrong");
endmodule
bind sae_execute sae_execute_chk sae_execute_chk_inst (.*);
`default_nettype wire

// ==== dv/sae_store_model.sv ====
/*
 Storage seen by the store group: counts each write and keeps its low data byte.
 Assumes writes are single-cycle strobes on the processor clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sae_store_model (
  input wire logic ref_clk,
  input wire logic mem_wr,
  input wire logic [21:0] mem_addr,
  input wire logic [21:0] mem_wdata,
  output logic [7:0] wr_count,
  input wire logic [7:0] peek_addr,
  output logic [7:0] peek_data
);
  logic [7:0] mem_reg [0:255];
  // Read-back so the bench can see what actually landed in storage
  assign peek_data = mem_reg[peek_addr];
  initial wr_count = 8'h00;
  // ==========================================
  // Write capture; a byte array is enough for the addresses in use
  always @(posedge ref_clk)
  begin
    if (mem_wr === 1'b1)
    begin
      mem_reg[mem_addr[7:0]] <= mem_wdata[7:0];
      wr_count <= wr_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== dv/store_add_execute_test.sv ====
/*
 Self-checking bench for sae_execute with a storage model on its far side.
 Assumes the three-cycle take/exec/write sequence of the execute block.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sae_consts.vh"
module store_add_execute_test;
  logic ref_clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0;
  logic dest_byte_sel = 1'b0, src_byte_sel = 1'b0;
  logic [3:0] op_code = 4'h0;
  logic [2:0] op_r1 = 3'h0, op_r2 = 3'h0;
  logic [1:0] op_rbyte = 2'h0;
  logic [6:0] op_disp = 7'h00;
  logic [7:0] op_imm = 8'h00, wr_count, n0;
  // Substitute pointers set before use
  logic [21:0] xf = 22'h00_1001, xh = 22'h00_2003, xb = 22'h00_3000;
  wire [21:0] mem_addr, mem_wdata, branch_addr;
  wire [1:0] mem_size;
  wire mem_wr, carry_latch, zero_latch, branch_taken, invalid_op_check, done;
  logic wr, br, ck, dn;
  wire [7:0] peek_data;
  integer fail_count = 0, checks_done = 0;
  always #12.5 ref_clk = ~ref_clk;
  sae_execute sae_execute_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .op_valid(op_valid),
    .op_code(op_code), .op_r1(op_r1), .op_r2(op_r2), .op_rbyte(op_rbyte),
    .dest_byte_sel(dest_byte_sel), .src_byte_sel(src_byte_sel),
    .op_disp(op_disp), .op_imm(op_imm),
    .xreg_full_base(xf), .xreg_half_base(xh), .xreg_byte_base(xb), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size),
    .carry_latch(carry_latch), .zero_latch(zero_latch), .branch_taken(branch_taken),
    .branch_addr(branch_addr), .invalid_op_check(invalid_op_check), .done(done));
  sae_store_model sae_store_model_inst (.ref_clk(ref_clk), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .wr_count(wr_count),
    .peek_addr(8'h7f), .peek_data(peek_data));
  // ==========================================
  // Shared tasks
  task chk(input logic [21:0] got, input logic [21:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task ex(input logic [3:0] c, input logic [2:0] a, b, input logic [1:0] r,
    input logic s, input logic [6:0] d, input logic [7:0] i);
    @(negedge ref_clk);
    {op_code, op_r1, op_r2, op_rbyte, dest_byte_sel, src_byte_sel, op_disp, op_imm} =
      {c, a, b, r, s, s, d, i};
    op_valid = 1'b1;
    @(negedge ref_clk);
    op_valid = 1'b0;
    // Pulses stand only between the first and second edges after the take
    @(negedge ref_clk);
    {wr, br, ck, dn} = {mem_wr, branch_taken, invalid_op_check, done};
    // Let the storage model take the strobe before the caller looks at it
    @(negedge ref_clk);
  endtask
  task lat(input logic [1:0] e);
    chk({20'h0, carry_latch, zero_latch}, {20'h0, e});
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task t_add_imm;
    ex(4'h5, 3'h0, 3'h0, 2'h0, 1'b1, 7'h00, 8'hff); // R1 = 00_00ff
    lat(2'b00);
    ex(4'h5, 3'h0, 3'h0, 2'h1, 1'b1, 7'h00, 8'h01); // R3 = 00_0001
    ex(4'h5, 3'h0, 3'h0, 2'h0, 1'b0, 7'h00, 8'h01); // Byte 0 only, byte 1 kept
    lat(2'b00);
    ex(4'h5, 3'h0, 3'h0, 2'h0, 1'b0, 7'h00, 8'hff); // Byte 0 overflows
    lat(2'b11);
    $display("add immediate done");
  endtask
  task t_stores;
    ex(4'h2, 3'h1, 3'h0, 2'h0, 1'b0, 7'h7e, 8'h00);
    chk(mem_addr, 22'h00_2080);
    chk({6'h0, mem_wdata[15:0]}, 22'h00_00ff);
    chk({20'h0, mem_size}, 22'h00_0001);
    lat(2'b11);
    ex(4'h1, 3'h0, 3'h3, 2'h0, 1'b0, 7'h04, 8'h00);
    chk(mem_addr, 22'h00_0004);
    chk(mem_wdata, 22'h00_0000);
    ex(4'h1, 3'h1, 3'h0, 2'h0, 1'b0, 7'h08, 8'h00);
    chk(mem_addr, 22'h00_1008);
    chk({20'h0, mem_size}, 22'h00_0002);
    ex(4'h3, 3'h0, 3'h0, 2'h0, 1'b1, 7'h7f, 8'h00);
    chk(mem_addr, 22'h00_307f);
    chk({14'h0, mem_wdata[7:0]}, 22'h00_00ff);
    chk({20'h0, mem_size}, 22'h00_0000);
    chk({14'h0, peek_data}, 22'h00_00ff);
    $display("stores done");
  endtask
  task t_autoinc;
    ex(4'h4, 3'h0, 3'h3, 2'h1, 1'b1, 7'h00, 8'h00); // Source and base both R3
    chk(mem_addr, 22'h00_0001);
    chk({14'h0, mem_wdata[7:0]}, 22'h00_0002);
    ex(4'h2, 3'h3, 3'h0, 2'h0, 1'b0, 7'h00, 8'h00);
    chk({6'h0, mem_wdata[15:0]}, 22'h00_0002);
    n0 = wr_count;
    ex(4'h4, 3'h0, 3'h0, 2'h1, 1'b1, 7'h00, 8'h00);
    chk({19'h0, ck, wr, 1'b0}, 22'h00_0004);
    repeat (2) @(negedge ref_clk);
    chk({14'h0, wr_count}, {14'h0, n0});
    $display("auto increment done");
  endtask
  task t_branch;
    ex(4'h6, 3'h0, 3'h3, 2'h0, 1'b0, 7'h00, 8'h00);
    chk({21'h0, br}, 22'h00_0001);
    chk(branch_addr, 22'h00_0002);
    lat(2'b11);
    ex(4'h6, 3'h3, 3'h3, 2'h0, 1'b0, 7'h00, 8'h00); // R3 = 4
    lat(2'b00);
    ex(4'h7, 3'h0, 3'h3, 2'h0, 1'b0, 7'h00, 8'h00);
    chk(branch_addr, 22'h00_0006);
    $display("add register done");
  endtask
  task t_byte_reg;
    ex(4'h5, 3'h0, 3'h0, 2'h0, 1'b0, 7'h00, 8'hff); // R1 = 00_ffff
    lat(2'b00);
    ex(4'h8, 3'h0, 3'h3, 2'h0, 1'b1, 7'h00, 8'h00); // R1 += byte 1 of R3, into byte X
    lat(2'b10);
    ex(4'h8, 3'h0, 3'h3, 2'h0, 1'b0, 7'h00, 8'h00); // Byte X nonzero, byte 0 zero
    lat(2'b01);
    ex(4'h7, 3'h1, 3'h1, 2'h0, 1'b0, 7'h00, 8'h00); // R1 halfword doubled
    lat(2'b00);
    ex(4'h1, 3'h1, 3'h3, 2'h0, 1'b0, 7'h00, 8'h00);
    chk(mem_addr, 22'h00_0004);
    chk(mem_wdata, 22'h01_0006);
    chk({21'h0, dn}, 22'h00_0001);
    ex(4'h0, 3'h1, 3'h3, 2'h0, 1'b0, 7'h00, 8'h00); // Unknown code: completion only
    chk({20'h0, dn, wr}, 22'h00_0002);
    lat(2'b00);
    $display("add byte register done");
  endtask
  initial
  begin
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_add_imm;
    t_stores;
    t_autoinc;
    t_branch;
    t_byte_reg;
    tally_and_finish;
  end
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    fail_count = fail_count + 1;
    tally_and_finish;
  end
endmodule
`default_nettype wire
